/* core/adcsc_consts.vh */
// constants for the a/d sequencer control block
// assumes one clock, pclk at 40 ns, and an apb register port
`ifndef ADCSC_CONSTS_VH
`define ADCSC_CONSTS_VH

// timing
// base clock period taken as one pclk; sized so products stay 16 bits
`define ADCSC_TCL_CYC 16'h0001
`define ADCSC_TCC_X24 16'h0018
`define ADCSC_TCC_X48 16'h0030
`define ADCSC_TCC_X96 16'h0060
`define ADCSC_CONV_STEPS 16'h000A

// register byte offsets
`define ADCSC_OFS_CTRL 8'h00
`define ADCSC_OFS_RESULT 8'h04
`define ADCSC_OFS_INJ_CTRL 8'h08
`define ADCSC_OFS_INJ_RESULT 8'h0C
`define ADCSC_OFS_STATUS 8'h10
`define ADCSC_OFS_MASK 8'h14
`define ADCSC_OFS_DIG_IN 8'h18
`define ADCSC_OFS_DIG_EN 8'h1C

// control register fields
`define ADCSC_CH_LO 0
`define ADCSC_CH_HI 3
`define ADCSC_MODE_LO 4
`define ADCSC_MODE_HI 5
`define ADCSC_WFR_BIT 6
`define ADCSC_OVR_SUSP_BIT 7
`define ADCSC_START_BIT 8
`define ADCSC_BUSY_BIT 9
`define ADCSC_STOP_BIT 10
`define ADCSC_SMP_LO 12
`define ADCSC_SMP_HI 13
`define ADCSC_CTC_LO 14
`define ADCSC_CTC_HI 15
`define ADCSC_CTRL_RST 16'h0000
`define ADCSC_CTRL_WMASK 16'hF0FF

// result registers: value low, channel high
`define ADCSC_RES_HI 9
`define ADCSC_RCH_LO 12
`define ADCSC_RCH_HI 15
`define ADCSC_INJ_REQ_BIT 8
`define ADCSC_INJ_PEND_BIT 9

// modes
`define ADCSC_MODE_SINGLE 2'b00
`define ADCSC_MODE_CONT 2'b01
`define ADCSC_MODE_SCAN 2'b10
`define ADCSC_MODE_SCAN_CONT 2'b11

// conversion clock codes
`define ADCSC_CTC_24 2'b00
`define ADCSC_CTC_96 2'b10
`define ADCSC_CTC_48 2'b11

// status bits
`define ADCSC_ST_DONE 0
`define ADCSC_ST_OVR 1
`define ADCSC_ST_INJ 2
`define ADCSC_ST_W 3

`endif

/* core/adcsc_timer.v */
// one-shot cycle timer for sample and convert phases
// assumes load is a one-cycle pulse with a nonzero count
`default_nettype none
module adcsc_timer (
   input wire pclk,
   input wire presetn,
   input wire load,
   input wire [15:0] count,
   output reg done
);
   reg [15:0] cnt;
   reg running;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 16'h0000;
         running <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (load) begin
            cnt <= count - 16'h0001;
            running <= 1'b1;
         end else if (running) begin
            if (cnt == 16'h0000) begin
               running <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt <= cnt - 16'h0001;
            end
         end
      end
   end
endmodule // adcsc_timer
`default_nettype wire

/* core/adcsc_dig_in.v */
// digital read-back of analog pins not used for conversion
// assumes pins are synchronous to pclk
`default_nettype none
module adcsc_dig_in (
   input wire pclk,
   input wire presetn,
   input wire [15:0] pins,
   input wire [15:0] enable,
   output reg [15:0] value
);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value <= 16'h0000;
      end else begin
         value <= pins & enable;
      end
   end
endmodule // adcsc_dig_in
`default_nettype wire

/* core/adcsc_top.v */
// a/d converter sequencer control with apb registers
// assumes an analog core that samples ana_channel while ana_sample is high
// and presents a settled 10-bit code on ana_data by the end of ana_convert
`include "adcsc_consts.vh"
`default_nettype none
// Contract
// - 10-bit results, 16 channels, shared sample-hold
// - overrun interrupt when unread result is overwritten
// - suspend option: hold next conversion until read
// - unused channel pins readable as digital inputs
// - single mode converts selected channel once
// - continuous mode repeats selected channel forever
// - scan single converts each selected channel once
// - scan continuous restarts scan indefinitely
// - each conversion raises interrupt or transfer request
// - wait-for-read buffers result, pauses until read
// - injected conversion stored in injection result register
// - continuous sequence resumes unchanged after injection
// - conversion clock 24, 96 or 48 base periods
// - sample time 1, 2, 4 or 8 conversion clocks
module adcsc_top (
   input wire pclk,
   input wire presetn,
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   input wire [9:0] ana_data,
   output reg [3:0] ana_channel,
   output wire ana_sample,
   output wire ana_convert,
   input wire [15:0] dig_pins,
   output wire adc_busy,
   output reg result_request,
   output wire irq
);
   localparam [4:0] S_IDLE = 5'b00001;
   localparam [4:0] S_NEXT = 5'b00010;
   localparam [4:0] S_SAMP = 5'b00100;
   localparam [4:0] S_CONV = 5'b01000;
   localparam [4:0] S_HOLD = 5'b10000;

   reg [4:0] state;
   reg [15:0] ctrl;
   reg [9:0] result;
   reg [3:0] result_ch;
   reg result_full;
   reg [9:0] temp_buf;
   reg [3:0] temp_ch;
   reg [3:0] inj_ch_sel;
   reg inj_pending;
   reg inj_active;
   reg [9:0] inj_result;
   reg [3:0] inj_result_ch;
   reg [`ADCSC_ST_W-1:0] status;
   reg [`ADCSC_ST_W-1:0] mask;
   reg [15:0] dig_en;
   reg [3:0] seq_ch;
   reg seq_more;
   reg stop_req;
   reg tmr_load;
   reg [15:0] tmr_count;
   wire tmr_done;
   wire [15:0] dig_value;

   wire wr_acc = psel & penable & pwrite;
   wire rd_setup = psel & ~penable & ~pwrite;
   // result counts as read at the setup edge, where its value is latched
   wire rd_result = rd_setup && (paddr == `ADCSC_OFS_RESULT);
   wire wr_ctrl = wr_acc && (paddr == `ADCSC_OFS_CTRL);
   wire wr_inj = wr_acc && (paddr == `ADCSC_OFS_INJ_CTRL);
   wire wr_status = wr_acc && (paddr == `ADCSC_OFS_STATUS);

   wire [1:0] mode = ctrl[`ADCSC_MODE_HI:`ADCSC_MODE_LO];
   wire [3:0] ch_field = ctrl[`ADCSC_CH_HI:`ADCSC_CH_LO];
   wire wfr = ctrl[`ADCSC_WFR_BIT];
   wire ovr_suspend = ctrl[`ADCSC_OVR_SUSP_BIT];
   wire continuous = mode[0];
   wire scanning = mode[1];
   // unread means full and not being read in this very cycle
   wire unread = result_full & ~rd_result;

   // conversion clock period in pclk cycles; reserved code 01 falls back to 24
   reg [15:0] tcc_cyc;
   always @* begin
      case (ctrl[`ADCSC_CTC_HI:`ADCSC_CTC_LO])
         `ADCSC_CTC_96: tcc_cyc = `ADCSC_TCC_X96 * `ADCSC_TCL_CYC;
         `ADCSC_CTC_48: tcc_cyc = `ADCSC_TCC_X48 * `ADCSC_TCL_CYC;
         default: tcc_cyc = `ADCSC_TCC_X24 * `ADCSC_TCL_CYC;
      endcase
   end
   wire [15:0] smp_cyc = tcc_cyc << ctrl[`ADCSC_SMP_HI:`ADCSC_SMP_LO];
   wire [15:0] conv_cyc = tcc_cyc * `ADCSC_CONV_STEPS;

   // next sequence channel and whether the sequence goes on
   reg [3:0] next_seq_ch;
   reg next_more;
   always @* begin
      next_seq_ch = seq_ch;
      next_more = continuous;
      if (scanning) begin
         if (seq_ch == 4'h0) begin
            next_seq_ch = ch_field;
         end else begin
            next_seq_ch = seq_ch - 4'h1;
            next_more = 1'b1;
         end
      end
   end

   assign adc_busy = ~state[0];
   assign ana_sample = state[2];
   assign ana_convert = state[3];
   assign pready = 1'b1;
   assign irq = |(status & mask);

   adcsc_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .load(tmr_load),
      .count(tmr_count),
      .done(tmr_done)
   );

   adcsc_dig_in u_dig_in (
      .pclk(pclk),
      .presetn(presetn),
      .pins(dig_pins),
      .enable(dig_en),
      .value(dig_value)
   );

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
         ctrl <= `ADCSC_CTRL_RST;
         result <= 10'h000;
         result_ch <= 4'h0;
         result_full <= 1'b0;
         temp_buf <= 10'h000;
         temp_ch <= 4'h0;
         inj_ch_sel <= 4'h0;
         inj_pending <= 1'b0;
         inj_active <= 1'b0;
         inj_result <= 10'h000;
         inj_result_ch <= 4'h0;
         status <= {`ADCSC_ST_W{1'b0}};
         mask <= {`ADCSC_ST_W{1'b0}};
         dig_en <= 16'h0000;
         seq_ch <= 4'h0;
         seq_more <= 1'b0;
         stop_req <= 1'b0;
         tmr_load <= 1'b0;
         tmr_count <= 16'h0000;
         ana_channel <= 4'h0;
         result_request <= 1'b0;
      end else begin
         tmr_load <= 1'b0;
         result_request <= 1'b0;
         // register writes; flags set below win over these clears
         if (wr_ctrl) begin
            ctrl <= pwdata[15:0] & `ADCSC_CTRL_WMASK;
            if (pwdata[`ADCSC_STOP_BIT]) begin
               stop_req <= 1'b1;
            end
         end
         if (wr_acc && paddr == `ADCSC_OFS_MASK) begin
            mask <= pwdata[`ADCSC_ST_W-1:0];
         end
         if (wr_acc && paddr == `ADCSC_OFS_DIG_EN) begin
            dig_en <= pwdata[15:0];
         end
         if (wr_inj) begin
            inj_ch_sel <= pwdata[`ADCSC_CH_HI:`ADCSC_CH_LO];
         end
         if (wr_status) begin
            status <= status & ~pwdata[`ADCSC_ST_W-1:0];
         end
         if (rd_result) begin
            result_full <= 1'b0;
         end
         // injection only taken while a continuous sequence runs
         if (wr_inj && pwdata[`ADCSC_INJ_REQ_BIT] && continuous && !state[0]) begin
            inj_pending <= 1'b1;
         end
         case (state)
            S_IDLE: begin
               if (wr_ctrl && pwdata[`ADCSC_START_BIT]) begin
                  seq_ch <= pwdata[`ADCSC_CH_HI:`ADCSC_CH_LO];
                  stop_req <= 1'b0;
                  state <= S_NEXT;
               end
            end
            S_NEXT: begin
               if (stop_req) begin
                  state <= S_IDLE;
               end else if (inj_pending) begin
                  inj_pending <= 1'b0;
                  inj_active <= 1'b1;
                  ana_channel <= inj_ch_sel;
                  tmr_count <= smp_cyc;
                  tmr_load <= 1'b1;
                  state <= S_SAMP;
               end else if (!(ovr_suspend && unread)) begin
                  ana_channel <= seq_ch;
                  tmr_count <= smp_cyc;
                  tmr_load <= 1'b1;
                  state <= S_SAMP;
               end
            end
            S_SAMP: begin
               if (tmr_done) begin
                  tmr_count <= conv_cyc;
                  tmr_load <= 1'b1;
                  state <= S_CONV;
               end
            end
            S_CONV: begin
               if (tmr_done) begin
                  if (inj_active) begin
                     inj_active <= 1'b0;
                     inj_result <= ana_data;
                     inj_result_ch <= ana_channel;
                     status[`ADCSC_ST_INJ] <= 1'b1;
                     state <= S_NEXT;
                  end else begin
                     seq_ch <= next_seq_ch;
                     seq_more <= next_more;
                     result_request <= 1'b1;
                     status[`ADCSC_ST_DONE] <= 1'b1;
                     if (unread && wfr) begin
                        temp_buf <= ana_data;
                        temp_ch <= ana_channel;
                        state <= S_HOLD;
                     end else begin
                        result <= ana_data;
                        result_ch <= ana_channel;
                        result_full <= 1'b1;
                        if (unread) begin
                           status[`ADCSC_ST_OVR] <= 1'b1;
                        end
                        state <= next_more ? S_NEXT : S_IDLE;
                     end
                  end
               end
            end
            S_HOLD: begin
               if (!unread) begin
                  result <= temp_buf;
                  result_ch <= temp_ch;
                  result_full <= 1'b1;
                  state <= seq_more ? S_NEXT : S_IDLE;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // read data registered in the setup phase, so reads need no wait state
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         if (paddr == `ADCSC_OFS_CTRL) begin
            if (rd_setup) begin
               prdata[15:0] <= ctrl;
               prdata[`ADCSC_BUSY_BIT] <= adc_busy;
            end
         end else if (paddr == `ADCSC_OFS_RESULT) begin
            if (rd_setup) begin
               prdata[`ADCSC_RES_HI:0] <= result;
               prdata[`ADCSC_RCH_HI:`ADCSC_RCH_LO] <= result_ch;
            end
         end else if (paddr == `ADCSC_OFS_INJ_CTRL) begin
            if (rd_setup) begin
               prdata[`ADCSC_CH_HI:`ADCSC_CH_LO] <= inj_ch_sel;
               prdata[`ADCSC_INJ_PEND_BIT] <= inj_pending | inj_active;
            end
         end else if (paddr == `ADCSC_OFS_INJ_RESULT) begin
            if (rd_setup) begin
               prdata[`ADCSC_RES_HI:0] <= inj_result;
               prdata[`ADCSC_RCH_HI:`ADCSC_RCH_LO] <= inj_result_ch;
            end
         end else if (paddr == `ADCSC_OFS_STATUS) begin
            if (rd_setup) begin
               prdata[`ADCSC_ST_W-1:0] <= status;
            end
         end else if (paddr == `ADCSC_OFS_MASK) begin
            if (rd_setup) begin
               prdata[`ADCSC_ST_W-1:0] <= mask;
            end
         end else if (paddr == `ADCSC_OFS_DIG_IN) begin
            if (rd_setup) begin
               prdata[15:0] <= dig_value;
            end
         end else if (paddr == `ADCSC_OFS_DIG_EN) begin
            if (rd_setup) begin
               prdata[15:0] <= dig_en;
            end
         end else begin
            pslverr <= 1'b1;
         end
      end
   end
endmodule // adcsc_top
`default_nettype wire

/* dv/adcsc_analog_model.sv */
// behavioural analog mux and sample-hold core
// assumes code is valid while ana_convert is high
`default_nettype none
module adcsc_analog_model (
   input wire logic pclk,
   input wire logic [3:0] ana_channel,
   input wire logic ana_convert,
   output logic [9:0] ana_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] last = 10'h000;
   always @(posedge pclk) begin
      if (ana_convert) begin
         last <= {ana_channel, 6'h25};
      end
   end
   // outside convert the code is stale: show its inverse, not a held value
   assign ana_data = ana_convert ? {ana_channel, 6'h25} : ~last;
endmodule // adcsc_analog_model
`default_nettype wire

/* dv/adcsc_top_asserts.sv */
// port checker for the a/d sequencer control block
// assumes one clock domain, bound onto adcsc_top
`default_nettype none
module adcsc_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [9:0] ana_data,
   input wire logic [3:0] ana_channel,
   input wire logic ana_sample,
   input wire logic ana_convert,
   input wire logic [15:0] dig_pins,
   input wire logic adc_busy,
   input wire logic result_request,
   input wire logic irq
);
   logic [11:0] smp_n;
   logic [11:0] cnv_n;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smp_n <= 12'h000;
         cnv_n <= 12'h000;
      end else begin
         smp_n <= ana_sample ? smp_n + 12'h001 : 12'h000;
         cnv_n <= ana_convert ? cnv_n + 12'h001 : 12'h000;
      end
   end
   a_phase_excl: assert property (!(ana_sample && ana_convert))
      else $error("sample and convert overlap");
   a_chan_hold: assert property (ana_convert && $past(ana_convert) |-> $stable(ana_channel))
      else $error("channel moved in convert");
   a_busy_cover: assert property (ana_sample || ana_convert |-> adc_busy)
      else $error("activity without busy");
   a_start_cause: assert property ($rose(adc_busy) |->
      $past(psel && penable && pwrite && paddr == 8'h00 && pwdata[8]))
      else $error("busy without start");
   a_req_pulse: assert property (result_request |=> !result_request)
      else $error("request too long");
   a_conv_follow: assert property ($fell(ana_sample) |-> ##[0:3] ana_convert)
      else $error("no convert after sample");
   a_conv_source: assert property ($rose(ana_convert) |->
      $past(ana_sample) || $past(ana_sample, 2) || $past(ana_sample, 3))
      else $error("convert without sample");
   a_smp_len: assert property ($fell(ana_sample) |-> smp_n >= 12'h017)
      else $error("sample too short");
   a_conv_len: assert property ($fell(ana_convert) |-> cnv_n >= 12'h0EF)
      else $error("convert too short");
   c_request: cover property (result_request);
   c_convert: cover property ($rose(ana_convert));
   c_irq: cover property (irq);
endmodule // adcsc_checker
bind adcsc_top adcsc_checker u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
   .prdata, .pready, .pslverr, .ana_data, .ana_channel, .ana_sample, .ana_convert, .dig_pins,
   .adc_busy, .result_request, .irq);
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the a/d sequencer control block
// assumes the analog model codes each result by its channel
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [15:0] dig_pins = 16'h0000;
   logic [31:0] rd;
   logic err;
   wire [31:0] prdata;
   wire [9:0] ana_data;
   wire [3:0] ana_channel;
   wire pready, pslverr, ana_sample, ana_convert, adc_busy, result_request, irq;
   int fails = 0;
   int total_checks = 0;
   int cyc = 0;
   adcsc_top uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .ana_data, .ana_channel, .ana_sample, .ana_convert, .dig_pins, .adc_busy,
      .result_request, .irq);
   adcsc_analog_model u_ana (.pclk, .ana_channel, .ana_convert, .ana_data);
   always #20 pclk = ~pclk;
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fails++;
         end_of_test();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [31:0] res(input logic [3:0] ch);
      return {16'h0000, ch, 2'b00, ch, 6'h25};
   endfunction
   function automatic logic [31:0] cfg(input logic [1:0] ctc, input logic [1:0] smp,
      input logic [1:0] ov_wf, input logic [1:0] mode, input logic [3:0] ch);
      return {16'h0000, ctc, smp, 4'h1, ov_wf, mode, ch};
   endfunction
   task automatic widle();
      int i;
      i = 0;
      while (adc_busy !== 1'b0 && i < 3000) begin
         @(negedge pclk);
         i++;
      end
      chk("idle", 0, adc_busy);
   endtask
   task automatic wreq();
      int i;
      i = 0;
      do begin
         @(negedge pclk);
         i++;
      end while (result_request !== 1'b1 && i < 3000);
      chk("request", 1, result_request);
   endtask
   task automatic stop(input logic [31:0] c);
      int i;
      i = 0;
      apb(1'b1, 8'h00, (c & 32'hFFFF_FEFF) | 32'h0000_0400);
      // a held result blocks the stop until it is read, so keep reading
      @(negedge pclk);
      while (adc_busy !== 1'b0 && i < 3000) begin
         apb(1'b0, 8'h04, 32'h0000_0000);
         @(negedge pclk);
         i++;
      end
      chk("stopped", 0, adc_busy);
      // leave the result register empty for the next scenario
      apb(1'b0, 8'h04, 32'h0000_0000);
   endtask
   task automatic t_single(input logic [1:0] ctc, input logic [1:0] smp, input logic [3:0] ch);
      int ns;
      int nc;
      int t;
      ns = 0;
      nc = 0;
      t = (ctc == 2'b10) ? 96 : (ctc == 2'b11) ? 48 : 24;
      apb(1'b1, 8'h00, cfg(ctc, smp, 2'b00, 2'b00, ch));
      do begin
         @(negedge pclk);
         ns += ana_sample;
         nc += ana_convert;
      end while (result_request !== 1'b1);
      chk("smp_len", 1, ns >= (t << smp) && ns <= (t << smp) + 3);
      chk("conv_len", 1, nc >= 10 * t && nc <= 10 * t + 3);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("result", res(ch), rd);
      widle();
   endtask
   task automatic t_scan(input logic [1:0] mode, input logic [3:0] top, input int n);
      logic [31:0] c;
      c = cfg(2'b00, 2'b00, 2'b00, mode, top);
      apb(1'b1, 8'h00, c);
      for (int k = 0; k < n; k++) begin
         wreq();
         apb(1'b0, 8'h04, 32'h0000_0000);
         chk("scan_res", res(top - 4'(k % (top + 1))), rd);
      end
      if (mode[0]) begin
         stop(c);
      end
      widle();
   endtask
   task automatic t_hold(input logic [1:0] ov_wf, input logic [3:0] ch);
      logic [31:0] c;
      c = cfg(2'b00, 2'b00, ov_wf, 2'b01, ch);
      apb(1'b1, 8'h00, c);
      wreq();
      repeat (700) @(negedge pclk);
      chk("held", 0, {ana_sample, ana_convert});
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("held_res", res(ch), rd);
      stop(c);
   endtask
   task automatic t_ovr();
      logic [31:0] c;
      int i;
      c = cfg(2'b00, 2'b00, 2'b00, 2'b01, 4'h3);
      apb(1'b1, 8'h14, 32'h0000_0000);
      apb(1'b1, 8'h10, 32'h0000_0007);
      apb(1'b1, 8'h00, c);
      wreq();
      apb(1'b1, 8'h08, 32'h0000_0109);
      i = 0;
      do begin
         repeat (20) @(negedge pclk);
         apb(1'b0, 8'h10, 32'h0000_0000);
         i++;
      end while (rd[2] !== 1'b1 && i < 100);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk("inj_res", res(4'h9), rd);
      repeat (600) @(negedge pclk);
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk("ovr_flag", 1, rd[1]);
      chk("irq_masked", 0, irq);
      apb(1'b1, 8'h14, 32'h0000_0002);
      @(negedge pclk);
      chk("irq_on", 1, irq);
      // overrun recurs each conversion, so look right after the clear
      apb(1'b1, 8'h10, 32'h0000_0002);
      @(negedge pclk);
      chk("irq_off", 0, irq);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("resumed", res(4'h3), rd);
      stop(c);
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("ctrl_rst", 0, rd);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk("unmapped", 1, err);
      dig_pins <= 16'hA5A5;
      apb(1'b1, 8'h1C, 32'h0000_00F0);
      apb(1'b0, 8'h18, 32'h0000_0000);
      chk("dig_in", 32'h0000_00A0, rd);
      // the reserved conversion clock code is never programmed
      t_single(2'b00, 2'b00, 4'h5);
      t_single(2'b10, 2'b01, 4'hF);
      t_single(2'b11, 2'b11, 4'h0);
      t_single(2'b00, 2'b10, 4'hA);
      t_scan(2'b10, 4'h2, 3);
      t_scan(2'b11, 4'h1, 5);
      t_hold(2'b01, 4'h6);
      t_hold(2'b10, 4'hC);
      t_ovr();
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
